//--- core/vsfs_pkg.sv
// Constants, types and register map of the valley-switch fault sequencer.
// Assumes a single 25 MHz system clock; all timing counts derive from it.
package vsfs_pkg;
    // Clock and times in their own units
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MIN_PERIOD_NS = 14500;
    localparam int unsigned CATCH_TO_NS = 4000;
    localparam int unsigned AUX_DELAY_NS = 1840;
    localparam int unsigned BLANK_NS = 170;
    localparam int unsigned FAULT_MS = 812;
    // Least times round up, longest times round down
    localparam int unsigned MIN_PERIOD_CYC = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CATCH_TO_CYC = CATCH_TO_NS / CLK_PERIOD_NS;
    localparam int unsigned AUX_DELAY_CYC = (AUX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAULT_CYC = (FAULT_MS * 1000000) / CLK_PERIOD_NS;
    // Counter widths
    localparam int unsigned CNT_W = 9;
    localparam int unsigned AUX_W = 6;
    localparam int unsigned BLK_W = 3;
    localparam int unsigned FT_W = 25;
    // Register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'hC;
    // Control fields
    localparam int unsigned CTRL_W = 2;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_HARD_BIT = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
    // Interrupt event bits
    localparam int unsigned INT_W = 4;
    localparam int unsigned INT_OCP = 0;
    localparam int unsigned INT_OVP = 1;
    localparam int unsigned INT_MODE = 2;
    localparam int unsigned INT_RETRY = 3;
    localparam logic [INT_W-1:0] INT_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_ON = 3'b001,
        ST_RAMP = 3'b010,
        ST_CATCH = 3'b011,
        ST_FAULT = 3'b100
    } vsfs_state_t;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic valley_detect_flag;
        logic dimmer_below_low;
        logic dimmer_above_high;
        logic switch_current_over;
        logic aux_over;
        logic ramp_cross;
        logic comp_above_min;
    } vsfs_cmp_t;
    localparam int unsigned CMP_W = $bits(vsfs_cmp_t);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } vsfs_bus_t;
endpackage : vsfs_pkg

//--- core/vsfs_sync.sv
// Two-flop synchronisers, one per comparator flag.
// Assumes each input is a slow level; pulses shorter than a clock may be lost.
`timescale 1ns/1ns
`default_nettype none
module vsfs_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[gi] <= 1'b0;
                    q_o[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= d_i[gi];
                    q_o[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
endmodule : vsfs_sync
`default_nettype wire

//--- core/vsfs_fault_timer.sv
// Shared fault timer: one start pulse runs it for a fixed number of cycles.
// Assumes the caller does not restart it while busy; a restart reloads it.
`timescale 1ns/1ns
`default_nettype none
module vsfs_fault_timer
    import vsfs_pkg::*;
#(
    parameter int unsigned CYCLES = FAULT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    localparam logic [FT_W-1:0] LAST = FT_W'(CYCLES - 1);
    logic [FT_W-1:0] cnt_q;
    wire last_w = busy_o && (cnt_q == LAST);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= last_w && !start_i;
            if (start_i) begin
                cnt_q <= '0;
                busy_o <= 1'b1;
            end else if (last_w) begin
                busy_o <= 1'b0;
            end else if (busy_o) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule : vsfs_fault_timer
`default_nettype wire

//--- core/vsfs_top.sv
// Switching-cycle sequencer for a valley-switching flyback controller.
// Assumes asynchronous comparator flags from the analog side, synchronised here, and a plain register port.
// Overview of operation
// - Each on-time ends when the per-cycle triggered ramp crosses the error amplifier level.
// - A turn-on starts a 14.5us minimum-period timer and no turn-on may come before it ends; here a turn-on from the wait state does not wait for it.
// - After that timer the switch turns on at the first valley flag or after the 4us catch timeout.
// - The catch timeout starts as soon as the ramp falls at the end of its rise.
// - Valley switching turns off below the 1V dimmer level and back on above 1.2V.
// - With valley switching off the switch turns on at the fixed ramp period, valley flag ignored; here it turns on at the 4us catch timeout.
// - The auxiliary sense is sampled 1.84us after each gate falling edge.
// - A sampled auxiliary level above its 1.75V threshold is an overvoltage fault.
// - An overvoltage fault holds the switch off 812ms, discharges compensation and stops the loop.
// - When the fault period ends the timer stops and the loop runs again.
// - Each cycle starts with the current sense forced low for 200ns, the 170ns rounded up to five clock cycles.
// - Current sense above 275mV turns the switch off at once for 812ms and discharges compensation.
// - A lasting fault gives hiccup retries every 812ms and normal running once it is gone.
// - The gate stays off until compensation is above the 280mV ramp floor.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module vsfs_top
    import vsfs_pkg::*;
#(
    parameter int unsigned FAULT_CYCLES = FAULT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire vsfs_bus_t bus_i,
    output logic [DATA_W-1:0] rd_data_o,
    // Analog comparator flags
    input wire vsfs_cmp_t cmp_i,
    // Power stage controls
    output logic gate_o,
    output logic ramp_start_o,
    output logic turn_on_blanking_o,
    output logic aux_sample_o,
    output logic comp_discharge_o,
    output logic loop_enable_o,
    // Interrupt
    output logic irq_o
);
    localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(MIN_PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] CATCH_LAST = CNT_W'(CATCH_TO_CYC - 1);
    localparam logic [BLK_W-1:0] BLANK_LOAD = BLK_W'(BLANK_CYC);
    localparam logic [AUX_W-1:0] AUX_LOAD = AUX_W'(AUX_DELAY_CYC);
    localparam logic [BLK_W-1:0] BLK_ONE = 3'h1;
    localparam logic [AUX_W-1:0] AUX_ONE = 6'h01;

    vsfs_state_t st_q;
    vsfs_state_t st_d;
    vsfs_cmp_t cmp_s;
    logic [CMP_W-1:0] cmp_sync;
    logic [CNT_W-1:0] ramp_q;
    logic [CNT_W-1:0] catch_q;
    logic [BLK_W-1:0] blk_cnt_q;
    logic [AUX_W-1:0] aux_cnt_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [INT_W-1:0] stat_q;
    logic [INT_W-1:0] stat_d;
    logic [INT_W-1:0] mask_q;
    logic valley_en_q;
    logic valley_en_d;
    logic ft_busy;
    logic ft_done;
    logic gate_d;

    // Comparator flags cross into the clock domain here
    vsfs_sync #(
        .W(CMP_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(cmp_i),
        .q_o(cmp_sync)
    );
    assign cmp_s = vsfs_cmp_t'(cmp_sync);

    // Register decode
    wire wr_ctrl = bus_i.wr && (bus_i.addr == REG_CTRL);
    wire wr_stat = bus_i.wr && (bus_i.addr == REG_INT_STAT);
    wire wr_mask = bus_i.wr && (bus_i.addr == REG_INT_MASK);
    wire run = ctrl_q[CTRL_RUN_BIT];
    wire force_hard = ctrl_q[CTRL_HARD_BIT];

    // Cycle timing terms
    wire in_ramp = (st_q == ST_ON) || (st_q == ST_RAMP);
    wire ramp_end = in_ramp && (ramp_q == RAMP_LAST);
    wire catch_end = (st_q == ST_CATCH) && (catch_q == CATCH_LAST);
    wire use_valley = valley_en_q && !force_hard;
    // Valley flag only counts in the catch window, so the minimum period holds for every turn-on from that window
    wire valley_hit = use_valley && cmp_s.valley_detect_flag;
    wire start_ok = run && cmp_s.comp_above_min;
    wire turn_on = start_ok && ((st_q == ST_WAIT) ||
        ((st_q == ST_CATCH) && (catch_end || valley_hit)));

    // Protection terms
    wire blanked = (blk_cnt_q != '0);
    wire ocp_trip = (st_q == ST_ON) && !blanked && cmp_s.switch_current_over;
    wire ovp_trip = aux_sample_o && cmp_s.aux_over;
    wire fault_trip = (ocp_trip || ovp_trip) && (st_q != ST_FAULT);
    wire mode_chg = (valley_en_d != valley_en_q);

    // Cycle sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_WAIT: begin
                if (turn_on) begin
                    st_d = ST_ON;
                end
            end
            ST_ON: begin
                if (ramp_end) begin
                    st_d = ST_CATCH;
                end else if (cmp_s.ramp_cross) begin
                    st_d = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (ramp_end) begin
                    st_d = ST_CATCH;
                end
            end
            ST_CATCH: begin
                if (turn_on) begin
                    st_d = ST_ON;
                end
            end
            ST_FAULT: begin
                if (ft_done) begin
                    st_d = ST_WAIT;
                end
            end
            default: begin
                st_d = ST_WAIT;
            end
        endcase
        if (fault_trip) begin
            st_d = ST_FAULT;
        end else if (!run && (st_q != ST_FAULT)) begin
            st_d = ST_WAIT;
        end
    end
    assign gate_d = (st_d == ST_ON);

    // Dimmer hysteresis; low level wins if both flags read high
    always_comb begin
        valley_en_d = valley_en_q;
        if (cmp_s.dimmer_below_low) begin
            valley_en_d = 1'b0;
        end else if (cmp_s.dimmer_above_high) begin
            valley_en_d = 1'b1;
        end
    end

    vsfs_fault_timer #(
        .CYCLES(FAULT_CYCLES)
    ) u_fault_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(fault_trip),
        .busy_o(ft_busy),
        .done_o(ft_done)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_WAIT;
            gate_o <= 1'b0;
            ramp_start_o <= 1'b0;
            comp_discharge_o <= 1'b0;
            loop_enable_o <= 1'b1;
            valley_en_q <= 1'b1;
        end else begin
            st_q <= st_d;
            gate_o <= gate_d;
            ramp_start_o <= turn_on && !fault_trip;
            comp_discharge_o <= (st_d == ST_FAULT);
            loop_enable_o <= (st_d != ST_FAULT);
            valley_en_q <= valley_en_d;
        end
    end

    // Ramp rise and catch window counters
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ramp_q <= '0;
            catch_q <= '0;
        end else begin
            if (turn_on || !in_ramp) begin
                ramp_q <= '0;
            end else if (!ramp_end) begin
                ramp_q <= ramp_q + 1'b1;
            end
            if (st_q != ST_CATCH) begin
                catch_q <= '0;
            end else if (!catch_end) begin
                catch_q <= catch_q + 1'b1;
            end
        end
    end

    // Turn-on blanking and auxiliary sample delay
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_cnt_q <= '0;
            turn_on_blanking_o <= 1'b0;
            aux_cnt_q <= '0;
            aux_sample_o <= 1'b0;
        end else begin
            if (gate_d && !gate_o) begin
                blk_cnt_q <= BLANK_LOAD;
            end else if (blanked) begin
                blk_cnt_q <= blk_cnt_q - 1'b1;
            end
            turn_on_blanking_o <= (gate_d && !gate_o) || (blk_cnt_q > BLK_ONE);
            if (gate_o && !gate_d) begin
                aux_cnt_q <= AUX_LOAD;
            end else if (aux_cnt_q != '0) begin
                aux_cnt_q <= aux_cnt_q - 1'b1;
            end
            aux_sample_o <= (aux_cnt_q == AUX_ONE);
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    wire [INT_W-1:0] ev = {ft_done, mode_chg, ovp_trip && fault_trip, ocp_trip && fault_trip};
    wire [INT_W-1:0] clr = wr_stat ? bus_i.wdata[INT_W-1:0] : '0;
    assign stat_d = (stat_q & ~clr) | ev;

    // Read mux; unmapped addresses read zero
    wire [DATA_W-1:0] status_w = {{(DATA_W-6){1'b0}}, ft_busy, valley_en_q, gate_o, st_q};
    wire [DATA_W-1:0] rd_mux =
        (bus_i.addr == REG_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} :
        (bus_i.addr == REG_STATUS) ? status_w :
        (bus_i.addr == REG_INT_STAT) ? {{(DATA_W-INT_W){1'b0}}, stat_q} :
        (bus_i.addr == REG_INT_MASK) ? {{(DATA_W-INT_W){1'b0}}, mask_q} : '0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
            stat_q <= INT_RESET;
            mask_q <= INT_RESET;
            irq_o <= 1'b0;
            rd_data_o <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_i.wdata[CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= bus_i.wdata[INT_W-1:0];
            end
            stat_q <= stat_d;
            irq_o <= |(stat_q & mask_q);
            rd_data_o <= bus_i.rd ? rd_mux : '0;
        end
    end

    // Helper: cycles since the last turn-on, saturating
    localparam int A_MINP = MIN_PERIOD_CYC - 1;
    localparam int A_CATCH = CATCH_TO_CYC;
    localparam int A_AUX = AUX_DELAY_CYC;
    logic [CNT_W-1:0] per_cnt_q;
    logic seen_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_cnt_q <= '0;
            seen_q <= 1'b0;
        end else if (gate_d && !gate_o) begin
            per_cnt_q <= '0;
            seen_q <= 1'b1;
        end else if (per_cnt_q != '1) begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_min_period;
        (gate_d && !gate_o && seen_q && st_q != ST_WAIT) |-> (per_cnt_q >= A_MINP);
    endproperty
    a_min_period: assert property (p_min_period) else $error("turn-on before minimum period");

    property p_catch_bound;
        $rose(st_q == ST_CATCH) |-> ##[1:A_CATCH] (st_q != ST_CATCH);
    endproperty
    a_catch_bound: assert property (p_catch_bound) else $error("catch window overran timeout");

    property p_hard_ignore;
        (st_q == ST_CATCH && !catch_end && (!valley_en_q || force_hard)) |=> !gate_o;
    endproperty
    a_hard_ignore: assert property (p_hard_ignore) else $error("early turn-on in hard switching");

    property p_dim_low;
        cmp_s.dimmer_below_low |=> !valley_en_q;
    endproperty
    a_dim_low: assert property (p_dim_low) else $error("valley mode not disabled");

    property p_aux_sample;
        $fell(gate_o) |-> ##A_AUX aux_sample_o;
    endproperty
    a_aux_sample: assert property (p_aux_sample) else $error("aux sample not at fixed delay");

    property p_ovp_fault;
        (aux_sample_o && cmp_s.aux_over && st_q != ST_FAULT) |=> (st_q == ST_FAULT) && !gate_o;
    endproperty
    a_ovp_fault: assert property (p_ovp_fault) else $error("overvoltage not faulted");

    property p_fault_outputs;
        (st_q == ST_FAULT) |-> !gate_o && comp_discharge_o && !loop_enable_o && (ft_busy || ft_done);
    endproperty
    a_fault_outputs: assert property (p_fault_outputs) else $error("fault outputs wrong");

    property p_retry;
        ft_done |=> (st_q == ST_WAIT) && loop_enable_o && !comp_discharge_o;
    endproperty
    a_retry: assert property (p_retry) else $error("no restart after fault period");

    property p_blank;
        $rose(gate_o) |-> turn_on_blanking_o [*5] ##1 !turn_on_blanking_o;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking length wrong");

    property p_ocp;
        (st_q == ST_ON && !blanked && cmp_s.switch_current_over) |=> !gate_o && (st_q == ST_FAULT);
    endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent not cut off");

    property p_comp_min;
        $rose(gate_o) |-> $past(cmp_s.comp_above_min);
    endproperty
    a_comp_min: assert property (p_comp_min) else $error("gate on below ramp floor");

    property p_ramp_start;
        $rose(gate_o) |-> ramp_start_o && turn_on_blanking_o;
    endproperty
    a_ramp_start: assert property (p_ramp_start) else $error("ramp not triggered at turn-on");

    property p_irq;
        ##1 (irq_o == |($past(stat_q) & $past(mask_q)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level mismatch");
endmodule : vsfs_top
`default_nettype wire

//--- tb/vsfs_stage.sv
// Stand-in for the power switch, transformer windings and sense comparators.
// Assumes the bench sets the knobs just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module vsfs_stage
    import vsfs_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // From the sequencer
    input wire logic gate_i,
    input wire logic discharge_i,
    // Bench knobs
    input wire logic comp_ok_i,
    input wire logic ocp_i,
    input wire logic ovp_i,
    input wire logic [15:0] on_len_i,
    input wire logic [15:0] dim_mv_i,
    // Comparator flags
    output vsfs_cmp_t cmp_o
);
    logic [15:0] on_n = 16'h0;
    logic [15:0] off_n = 16'h0;
    always @(posedge ref_clk_i) begin
        on_n <= gate_i ? on_n + 16'h1 : 16'h0;
        off_n <= gate_i ? 16'h0 : off_n + 16'h1;
    end
    always_comb begin
        cmp_o.ramp_cross = gate_i && on_n >= on_len_i;
        // Ringing gives a valley every 20 cycles once the winding has reset
        cmp_o.valley_detect_flag = !gate_i && off_n >= 16'd30 && (off_n - 16'd30) % 16'd20 < 16'd3;
        cmp_o.dimmer_below_low = dim_mv_i < 16'd1000;
        cmp_o.dimmer_above_high = dim_mv_i > 16'd1200;
        // Current flows only while the switch conducts, spike included
        cmp_o.switch_current_over = gate_i && ocp_i;
        cmp_o.aux_over = ovp_i;
        // A discharged compensation node sits below the ramp floor
        cmp_o.comp_above_min = comp_ok_i && !discharge_i;
    end
endmodule : vsfs_stage
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the switching sequencer and its power stage model.
// Assumes a short fault period through the FAULT_CYCLES parameter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import vsfs_pkg::*;
    localparam int FLT = 200;
    localparam int MP = MIN_PERIOD_CYC;
    localparam int HP = MIN_PERIOD_CYC + CATCH_TO_CYC;
    logic clk;
    logic rst_n;
    vsfs_bus_t bus;
    logic [31:0] rd_data;
    vsfs_cmp_t cmp;
    logic gate, ramp_st, blank, aux_s, disch, loop_en, irq;
    logic comp_ok, ocp, ovp;
    logic [15:0] on_len, dim;
    int fails = 0;
    int compares = 0;

    vsfs_top #(.FAULT_CYCLES(FLT)) vsfs_top_i (.ref_clk_i(clk), .rst_n_i(rst_n), .bus_i(bus),
        .rd_data_o(rd_data), .cmp_i(cmp), .gate_o(gate), .ramp_start_o(ramp_st),
        .turn_on_blanking_o(blank), .aux_sample_o(aux_s), .comp_discharge_o(disch),
        .loop_enable_o(loop_en), .irq_o(irq));
    vsfs_stage vsfs_stage_i (.ref_clk_i(clk), .gate_i(gate), .discharge_i(disch), .comp_ok_i(comp_ok),
        .ocp_i(ocp), .ovp_i(ovp), .on_len_i(on_len), .dim_mv_i(dim), .cmp_o(cmp));

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic inr(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : inr

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(rd_data, exp);
    endtask : rchk

    // Waits, bounded, until the gate shows the level; n counts the cycles
    task automatic wgate(input logic v, output int n);
        n = 0;
        while (gate !== v && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            $display("Error at %0t: gate stuck", $time);
        end
    endtask : wgate

    // On-time and full period, from one turn-on to the next
    task automatic cyc(output int on, output int per);
        int n;
        wgate(1'b0, n);
        wgate(1'b1, n);
        wgate(1'b0, on);
        wgate(1'b1, per);
        per += on;
    endtask : cyc

    task automatic t_regs();
        rchk(REG_CTRL, 32'h1);
        rchk(REG_INT_STAT, 32'h0);
        rchk(REG_INT_MASK, 32'h0);
        rchk(REG_STATUS, 32'h10);
        rchk(4'h2, 32'h0);
        wr(REG_INT_MASK, 32'hF);
        rchk(REG_INT_MASK, 32'hF);
        wr(REG_INT_MASK, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
    endtask : t_regs

    task automatic t_start();
        int n;
        int hi;
        hi = 0;
        repeat (400) begin
            @(negedge clk);
            hi += gate;
        end
        chk(hi, 0);
        @(posedge clk);
        comp_ok <= 1'b1;
        wgate(1'b1, n);
        chk(inr(n, 1, 6), 1'b1);
    endtask : t_start

    task automatic t_valley();
        int on;
        int per;
        @(posedge clk);
        on_len <= 16'd40;
        cyc(on, per);
        cyc(on, per);
        chk(inr(on, 40, 45), 1'b1);
        chk(inr(per, MP, HP - 2), 1'b1);
        @(posedge clk);
        on_len <= 16'd120;
        cyc(on, per);
        cyc(on, per);
        chk(inr(on, 120, 125), 1'b1);
        chk(inr(per, MP, HP - 2), 1'b1);
        wr(REG_CTRL, 32'h3);
        cyc(on, per);
        cyc(on, per);
        chk(inr(per, HP - 1, HP + 2), 1'b1);
        wr(REG_CTRL, 32'h1);
    endtask : t_valley

    task automatic t_dim();
        int on;
        int per;
        int lv[4] = '{1100, 900, 1100, 1300};
        logic hard[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        wr(REG_INT_STAT, 32'hF);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dim <= 16'(lv[i]);
            cyc(on, per);
            cyc(on, per);
            chk(inr(per, HP - 1, HP + 2), hard[i]);
        end
        rchk(REG_INT_STAT, 32'h4);
    endtask : t_dim

    task automatic t_blank_aux();
        int n;
        wgate(1'b0, n);
        wgate(1'b1, n);
        chk(ramp_st, 1'b1);
        n = 0;
        while (blank === 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        chk(n, BLANK_CYC);
        wgate(1'b0, n);
        n = 0;
        while (aux_s !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(n, AUX_DELAY_CYC);
        @(negedge clk);
        chk(aux_s, 1'b0);
        // Clearing run parks the sequencer in its wait state with the gate off
        wr(REG_CTRL, 32'h0);
        n = 0;
        repeat (HP) begin
            @(negedge clk);
            n += gate;
        end
        chk(n, 0);
        rchk(REG_STATUS, 32'h10);
        wr(REG_CTRL, 32'h1);
    endtask : t_blank_aux

    // Counts the fault period; gate must stay low throughout
    task automatic t_fault(output int f);
        int g;
        f = 0;
        g = 0;
        while (disch === 1'b1 && f < 300) begin
            f++;
            @(negedge clk);
            g += gate;
        end
        chk(inr(f, FLT - 1, FLT + 1), 1'b1);
        chk(g, 0);
    endtask : t_fault

    task automatic t_ocp();
        int n;
        int h;
        int on;
        wr(REG_INT_STAT, 32'hF);
        wr(REG_INT_MASK, 32'h1);
        wgate(1'b0, n);
        @(posedge clk);
        ocp <= 1'b1;
        wgate(1'b1, n);
        wgate(1'b0, h);
        chk(inr(h, BLANK_CYC, BLANK_CYC + 4), 1'b1);
        chk(disch, 1'b1);
        chk(loop_en, 1'b0);
        t_fault(n);
        chk(irq, 1'b1);
        wgate(1'b1, n);
        chk(inr(n, 1, 8), 1'b1);
        wgate(1'b0, h);
        chk(inr(h, BLANK_CYC, BLANK_CYC + 4), 1'b1);
        // Second fault is timed from its start; the overcurrent goes away before the retry
        t_fault(n);
        @(posedge clk);
        ocp <= 1'b0;
        wr(REG_INT_MASK, 32'h0);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        rchk(REG_INT_STAT, 32'h9);
        cyc(on, h);
        chk(inr(h, MP, HP + 2), 1'b1);
        wr(REG_INT_STAT, 32'hF);
        wr(REG_INT_MASK, 32'hF);
        rchk(REG_INT_STAT, 32'h0);
        chk(irq, 1'b0);
    endtask : t_ocp

    task automatic t_ovp();
        int n;
        wr(REG_INT_STAT, 32'hF);
        wgate(1'b1, n);
        @(posedge clk);
        ovp <= 1'b1;
        n = 0;
        while (aux_s !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (disch !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk(inr(n, 0, 3), 1'b1);
        @(posedge clk);
        ovp <= 1'b0;
        @(negedge clk);
        chk(loop_en, 1'b0);
        chk(irq, 1'b1);
        t_fault(n);
        chk(loop_en, 1'b1);
        wgate(1'b1, n);
        chk(inr(n, 1, 8), 1'b1);
        rchk(REG_INT_STAT, 32'hA);
    endtask : t_ovp

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        comp_ok = 1'b0;
        ocp = 1'b0;
        ovp = 1'b0;
        on_len = 16'd60;
        dim = 16'd1500;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_start();
        t_valley();
        t_dim();
        t_blank_aux();
        t_ocp();
        t_ovp();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
